// ### shared/ladder_dac_pkg.sv
// package: register map, field layout and reset values of the ladder converter control
package ladder_dac_pkg;
  // register byte offsets
  localparam logic [11:0] off_control_0 = 12'h000;
  localparam logic [11:0] off_level = 12'h004;
  localparam logic [11:0] off_status = 12'h008;
  // converter_control_0 fields
  localparam int enable_bit = 7;
  localparam int out_enable_bit = 5;
  localparam int lps_bit = 4;
  localparam int pss_lsb = 2;
  localparam int nss_bit = 0;
  localparam int pss_width = 2;
  // converter_level_register fields
  localparam int code_width = 5;
  localparam int tap_count = 32;
  // reset values and the full-scale code
  localparam logic [7:0] control_0_reset = 8'h00;
  localparam logic [4:0] code_reset = 5'h00;
  localparam logic [4:0] code_all_ones = 5'h1f;
  // positive source codes: 0 supply, 1 external pin, 2 fixed internal reference
  localparam logic [1:0] pss_fixed_ref = 2'h2;
  // bus constants
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [31:0] read_zero = 32'h00000000;
endpackage

// ### shared/ladder_cfg_if.sv
// interface: configuration carried from the register file to the switch decoder
`timescale 1ns/1ps
`default_nettype none
interface ladder_cfg_if;
  logic enable;
  logic out_enable;
  logic low_power_source_select;
  logic [1:0] positive_source_select;
  logic negative_source_select;
  logic [4:0] ladder_code;
  modport regs (output enable, output out_enable, output low_power_source_select,
    output positive_source_select, output negative_source_select, output ladder_code);
  modport decode (input enable, input out_enable, input low_power_source_select,
    input positive_source_select, input negative_source_select, input ladder_code);
endinterface
`default_nettype wire

// ### hw/ladder_switch_decode.sv
// module: combinational decode of the ladder code and source selection into switch controls
`timescale 1ns/1ps
`default_nettype none
module ladder_switch_decode
  import ladder_dac_pkg::*;
(
  // configuration
  ladder_cfg_if.decode cfg,
  // switch controls
  output logic [tap_count-1:0] next_tap_select,
  output logic next_pos_connect,
  output logic next_neg_connect,
  output logic next_pin_connect,
  output logic next_fixed_ref_route
);
  // one tap line per code value, lowest tap for code zero
  genvar g;
  generate
    for (g = 0; g < tap_count; g = g + 1)
    begin : g_tap
      assign next_tap_select[g] = (cfg.ladder_code == code_width'(g));
    end
  endgenerate

  // sources: full ladder when enabled, else low-power source select drops one end
  assign next_pos_connect = cfg.enable | cfg.low_power_source_select;
  assign next_neg_connect = cfg.enable | ~cfg.low_power_source_select;
  assign next_pin_connect = cfg.out_enable;
  // positive clamp on the fixed reference carries that level to the pin
  assign next_fixed_ref_route = ~cfg.enable & cfg.low_power_source_select
    & (cfg.positive_source_select == pss_fixed_ref)
    & (cfg.ladder_code == code_all_ones) & cfg.out_enable;
endmodule // ladder_switch_decode
`default_nettype wire

// ### hw/ladder_dac_control.sv
// module: ladder converter control with AHB-Lite register slave and switch outputs
// How it works
// - low-power select set drops negative source
// - low-power select clear drops positive source
// - positive clamp on fixed reference, full code, pin on: routes it out
// - sleep wake leaves control register unchanged
// - reset disables converter, disconnects output pin
// - reset clears the five-bit ladder code
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ladder_dac_control
  import ladder_dac_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sleep state of the device, synchronous to hclk
  input wire logic sleep_wake,
  // analogue switch controls
  output logic [tap_count-1:0] tap_select,
  output logic pos_source_connect,
  output logic neg_source_connect,
  output logic converter_output_pin_connect,
  output logic fixed_ref_to_pin
);
  ladder_cfg_if cfg ();

  // register state
  logic [7:0] converter_control_0;
  logic [4:0] ladder_code;
  logic wr_pending;
  logic [11:0] wr_addr;
  logic [31:0] rd_data;

  // address phase decode
  wire logic take = hsel & hready & (htrans == htrans_nonseq);
  wire logic take_wr = take & hwrite;
  wire logic wr_ctl = wr_pending & (wr_addr == off_control_0);
  wire logic wr_lvl = wr_pending & (wr_addr == off_level);
  wire logic [11:0] rd_addr = haddr[11:0];
  wire logic [7:0] next_control_0 = wr_ctl ? hwdata[7:0] : converter_control_0;
  wire logic [4:0] next_ladder_code = wr_lvl ? hwdata[4:0] : ladder_code;
  // reads return the register word, unmapped offsets read zero
  wire logic [31:0] next_rd_data =
    (rd_addr == off_control_0) ? {24'h000000, converter_control_0} :
    (rd_addr == off_level) ? {27'h0000000, ladder_code} :
    (rd_addr == off_status) ? {26'h0000000, fixed_ref_to_pin, converter_output_pin_connect,
      pos_source_connect, neg_source_connect, sleep_wake, 1'b0} : read_zero;

  // register fields onto the configuration interface
  assign cfg.enable = converter_control_0[enable_bit];
  assign cfg.out_enable = converter_control_0[out_enable_bit];
  assign cfg.low_power_source_select = converter_control_0[lps_bit];
  assign cfg.positive_source_select = converter_control_0[pss_lsb +: pss_width];
  assign cfg.negative_source_select = converter_control_0[nss_bit];
  assign cfg.ladder_code = ladder_code;

  logic [tap_count-1:0] next_tap_select;
  logic next_pos_connect;
  logic next_neg_connect;
  logic next_pin_connect;
  logic next_fixed_ref_route;

  ladder_switch_decode u_decode (
    .cfg(cfg.decode),
    .next_tap_select(next_tap_select),
    .next_pos_connect(next_pos_connect),
    .next_neg_connect(next_neg_connect),
    .next_pin_connect(next_pin_connect),
    .next_fixed_ref_route(next_fixed_ref_route)
  );

  // bus data phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      wr_addr <= 12'h000;
      rd_data <= read_zero;
    end
    else
    begin
      wr_pending <= take_wr;
      if (take_wr)
        wr_addr <= haddr[11:0];
      if (take & ~hwrite)
        rd_data <= next_rd_data;
    end
  end

  // control registers; sleep and wake never touch them, only bus writes and reset do
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      converter_control_0 <= control_0_reset;
      ladder_code <= code_reset;
    end
    else
    begin
      converter_control_0 <= next_control_0;
      ladder_code <= next_ladder_code;
    end
  end

  // registered switch outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tap_select <= {{(tap_count-1){1'b0}}, 1'b1};
      pos_source_connect <= 1'b0;
      neg_source_connect <= 1'b1;
      converter_output_pin_connect <= 1'b0;
      fixed_ref_to_pin <= 1'b0;
    end
    else
    begin
      tap_select <= next_tap_select;
      pos_source_connect <= next_pos_connect;
      neg_source_connect <= next_neg_connect;
      converter_output_pin_connect <= next_pin_connect;
      fixed_ref_to_pin <= next_fixed_ref_route;
    end
  end

  // bus answers: zero wait, always okay
  assign hrdata = rd_data;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // low-power select set, converter off: negative end open next cycle
  property p_neg_off;
    @(posedge hclk) disable iff (!hresetn)
    (!cfg.enable && cfg.low_power_source_select) |=> !neg_source_connect;
  endproperty
  a_neg_off: assert property (p_neg_off) else $error("negative source not dropped");

  // low-power select clear, converter off: positive end open next cycle
  property p_pos_off;
    @(posedge hclk) disable iff (!hresetn)
    (!cfg.enable && !cfg.low_power_source_select) |=> !pos_source_connect;
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("positive source not dropped");

  // fixed reference route follows the positive clamp setup
  property p_fixed_route;
    @(posedge hclk) disable iff (!hresetn)
    $rose(fixed_ref_to_pin) |-> $past(ladder_code) == code_all_ones && !$past(cfg.enable);
  endproperty
  a_fixed_route: assert property (p_fixed_route) else $error("bad reference route");

  // control register holds without a write, across sleep and wake
  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!wr_ctl && $changed(sleep_wake)) |=> $stable(converter_control_0);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed on wake");

  // after reset release converter stays off until written
  property p_reset_off;
    @(posedge hclk) $rose(hresetn) |-> !converter_output_pin_connect && !cfg.enable;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("converter on after reset");

  // code zero after reset release
  property p_reset_code;
    @(posedge hclk) $rose(hresetn) |-> ladder_code == code_reset;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("code not cleared");

  // exactly one tap, matching the previous code
  property p_tap;
    @(posedge hclk) disable iff (!hresetn)
    ##1 ($onehot(tap_select) && tap_select[$past(ladder_code)]);
  endproperty
  a_tap: assert property (p_tap) else $error("tap does not match code");

  // level write lands two cycles after its address phase
  property p_level_write;
    @(posedge hclk) disable iff (!hresetn)
    (take_wr && (haddr[11:0] == off_level)) |-> ##2 (ladder_code == $past(hwdata[4:0]));
  endproperty
  a_level_write: assert property (p_level_write) else $error("level write lost");

  // converter on keeps the negative end on the ladder
  property p_neg_on;
    @(posedge hclk) disable iff (!hresetn)
    cfg.enable |=> neg_source_connect;
  endproperty
  a_neg_on: assert property (p_neg_on) else $error("negative end open");

  // converter on keeps the positive end on the ladder
  property p_pos_on;
    @(posedge hclk) disable iff (!hresetn)
    cfg.enable |=> pos_source_connect;
  endproperty
  a_pos_on: assert property (p_pos_on) else $error("positive end open");

  // converter off leaves exactly one end connected, never both or none
  property p_one_end;
    @(posedge hclk) disable iff (!hresetn)
    !cfg.enable |=> (pos_source_connect != neg_source_connect);
  endproperty
  a_one_end: assert property (p_one_end) else $error("both ends switched");

  // output pin stays disconnected unless its enable is set
  property p_pin_off;
    @(posedge hclk) disable iff (!hresetn)
    !cfg.out_enable |=> !converter_output_pin_connect;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");

  // pin enable connects the ladder output one cycle later
  property p_pin_on;
    @(posedge hclk) disable iff (!hresetn)
    cfg.out_enable |=> converter_output_pin_connect;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin not connected");

  // reference route only exists with the pin connected
  property p_ref_pin;
    @(posedge hclk) disable iff (!hresetn)
    fixed_ref_to_pin |-> converter_output_pin_connect;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("route without pin");

  // reference route only in the positive-clamp switch state
  property p_ref_ends;
    @(posedge hclk) disable iff (!hresetn)
    fixed_ref_to_pin |-> (pos_source_connect && !neg_source_connect);
  endproperty
  a_ref_ends: assert property (p_ref_ends) else $error("route with bad ends");

  // full positive clamp on the fixed reference makes the route next cycle
  property p_ref_set;
    @(posedge hclk) disable iff (!hresetn)
    (!cfg.enable && cfg.low_power_source_select && cfg.out_enable
      && (cfg.positive_source_select == pss_fixed_ref) && (ladder_code == code_all_ones))
      |=> fixed_ref_to_pin;
  endproperty
  a_ref_set: assert property (p_ref_set) else $error("route not made");

  // any code short of full scale breaks the route
  property p_ref_code;
    @(posedge hclk) disable iff (!hresetn)
    (ladder_code != code_all_ones) |=> !fixed_ref_to_pin;
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("route off full code");

  // enabled converter never routes the reference
  property p_ref_en;
    @(posedge hclk) disable iff (!hresetn)
    cfg.enable |=> !fixed_ref_to_pin;
  endproperty
  a_ref_en: assert property (p_ref_en) else $error("route while on");

  // all-ones code picks the highest tap
  property p_tap_top;
    @(posedge hclk) disable iff (!hresetn)
    (ladder_code == code_all_ones) |=> tap_select[tap_count-1];
  endproperty
  a_tap_top: assert property (p_tap_top) else $error("top tap missing");

  // zero code picks the lowest tap
  property p_tap_low;
    @(posedge hclk) disable iff (!hresetn)
    (ladder_code == code_reset) |=> tap_select[0];
  endproperty
  a_tap_low: assert property (p_tap_low) else $error("bottom tap missing");

  // a control write takes the data phase word
  property p_ctl_wr;
    @(posedge hclk) disable iff (!hresetn)
    wr_ctl |=> (converter_control_0 == $past(hwdata[7:0]));
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");

  // without a control write the register keeps its contents
  property p_ctl_keep;
    @(posedge hclk) disable iff (!hresetn)
    !wr_ctl |=> $stable(converter_control_0);
  endproperty
  a_ctl_keep: assert property (p_ctl_keep) else $error("control changed unasked");

  // without a level write the code keeps its value
  property p_code_keep;
    @(posedge hclk) disable iff (!hresetn)
    !wr_lvl |=> $stable(ladder_code);
  endproperty
  a_code_keep: assert property (p_code_keep) else $error("code changed unasked");

  // control read returns the register in the data phase
  property p_rd_ctl;
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && (haddr[11:0] == off_control_0))
      |=> (hrdata == {24'h000000, $past(converter_control_0)});
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

  // level read returns the code in the data phase
  property p_rd_code;
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && (haddr[11:0] == off_level))
      |=> (hrdata == {27'h0, $past(ladder_code)});
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("level read wrong");
endmodule // ladder_dac_control
`default_nettype wire

// ### verif/ladder_analog_model.sv
// model: analogue ladder, reference switches and output pin level
`timescale 1ns/1ps
`default_nettype none
module ladder_analog_model
(
  // clock for the released-pin pattern
  input wire logic clk,
  // switch controls
  input wire logic [31:0] tap_select,
  input wire logic pos_on,
  input wire logic neg_on,
  input wire logic pin_on,
  // pin level in ladder steps
  output logic [5:0] pin_level
);
  logic [5:0] tap;
  logic idle = 1'b0;
  // one-hot tap to step; a released pin toggles so no stale level passes
  always_comb
  begin
    tap = 6'h00;
    for (int i = 0; i < 32; i++) if (tap_select[i]) tap = 6'(i);
  end
  always_ff @(posedge clk) idle <= ~idle;
  // only one source on: the ladder sits at that rail
  assign pin_level = !pin_on ? {6{idle}} : (pos_on && !neg_on) ? 6'h20 :
    (!pos_on && neg_on) ? 6'h00 : tap;
endmodule // ladder_analog_model
`default_nettype wire

// ### verif/ladder_dac_low_power_control_bench.sv
// bench: ladder converter control against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module ladder_dac_low_power_control_bench;
  import ladder_dac_pkg::*;
  logic hclk, hresetn, hsel, hwrite, sleep_wake, hreadyout, hresp, pos, neg, pin, fixed;
  logic [31:0] haddr, hwdata, hrdata, tap, rd, seed;
  logic [1:0] htrans;
  logic [5:0] lvl;
  int err_total, tests_run, ctl, code;
  ladder_dac_control ladder_dac_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_wake(sleep_wake), .tap_select(tap), .pos_source_connect(pos),
    .neg_source_connect(neg), .converter_output_pin_connect(pin), .fixed_ref_to_pin(fixed));
  ladder_analog_model ladder_analog_model_i (.clk(hclk), .tap_select(tap), .pos_on(pos),
    .neg_on(neg), .pin_on(pin), .pin_level(lvl));
  // clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // expected switches {fixed, pin, pos, neg}
  function automatic logic [3:0] sw();
    logic en, lps;
    en = ctl[7];
    lps = ctl[4];
    return {!en && lps && ctl[3:2] == 2 && code == 31 && ctl[5], ctl[5] == 1, en || lps,
      en || !lps};
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  // one single transfer; the model follows writes
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (w && a == off_control_0) ctl = d[7:0];
    if (w && a == off_level) code = d[4:0];
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
    cmp("hresp", 32'h0, hresp);
    cmp("hreadyout", 32'h1, hreadyout);
    cmp("read", a == 0 ? ctl : a == 4 ? code : a == 8 ? {sw(), sleep_wake, 1'b0} : 0, rd);
  endtask
  // switch outputs after the register update has landed
  task automatic chk;
    logic [3:0] e;
    e = sw();
    @(posedge hclk);
    @(posedge hclk);
    #1;
    cmp("tap", 32'h1 << code, tap);
    cmp("neg", e[0], neg);
    cmp("pos", e[1], pos);
    cmp("pin", e[2], pin);
    cmp("fixed", e[3], fixed);
    if (e[2]) cmp("level", !ctl[7] ? (ctl[4] ? 32 : 0) : code, lvl);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(3000 * 100);
    err_total++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    seed = 32'h57b16fc6;
    {hresetn, hsel, hwrite, sleep_wake, htrans, haddr, hwdata} = '0;
    {ctl, code, err_total, tests_run} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk;
    rdc(12'h000);
    rdc(12'h004);
    // enabled converter with pin on, boundary codes then random codes
    wr(12'h000, 32'ha0);
    for (int i = 0; i < 20; i++)
    begin
      wr(12'h004, i < 2 ? i * 31 : $random(seed));
      chk;
    end
    // low-power state, both ends
    wr(12'h004, 32'h5);
    wr(12'h000, 32'h10);
    chk;
    wr(12'h000, 32'h00);
    chk;
    // positive clamp routes the fixed reference; one code short does not
    wr(12'h000, 32'h38);
    wr(12'h004, 32'h1f);
    chk;
    rdc(12'h008);
    wr(12'h004, 32'h1e);
    chk;
    // negative clamp
    wr(12'h000, 32'h20);
    wr(12'h004, 32'h00);
    chk;
    rdc(12'h008);
    // reference off before sleep, control kept across wake
    wr(12'h000, 32'h14);
    @(posedge hclk) sleep_wake <= 1'b1;
    repeat (5) @(posedge hclk);
    rdc(12'h008);
    @(posedge hclk) sleep_wake <= 1'b0;
    rdc(12'h000);
    chk;
    rdc(12'h00c);
    // reset in mid-run
    wr(12'h000, 32'hb5);
    wr(12'h004, 32'h11);
    @(posedge hclk) hresetn <= 1'b0;
    @(posedge hclk) hresetn <= 1'b1;
    ctl = 0;
    code = 0;
    chk;
    rdc(12'h000);
    rdc(12'h004);
    end_of_test;
  end
endmodule // ladder_dac_low_power_control_bench
`default_nettype wire
